// ===== csl_pkg.sv
package csl_pkg;
  // Security bit positions within the three-bit fuse word
  localparam int SEC_BIT1 = 0;
  localparam int SEC_BIT2 = 1;
  localparam int SEC_BIT3 = 2;
  localparam logic [2:0] SEC_NONE = 3'h0;
  localparam logic [2:0] SEC_LVL2 = 3'h1;
  localparam logic [2:0] SEC_LVL3 = 3'h3;
  localparam logic [2:0] SEC_LVL4 = 3'h7;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  // Edges after release before the latched access level freezes
  localparam logic [2:0] EA_SETTLE = 3'h5;

  typedef enum logic [3:0] {
    CSL_LVL1 = 4'h1,
    CSL_LVL2 = 4'h2,
    CSL_LVL3 = 4'h4,
    CSL_LVL4 = 4'h8
  } csl_level_t;

  typedef struct packed {
    logic code_read_block;
    logic ea_latched_mode;
    logic prog_block;
    logic verify_block;
    logic ext_exec_block;
  } csl_prot_t;

  typedef struct packed {
    logic code_table_read;
    logic from_external;
    logic target_internal;
  } csl_fetch_t;
endpackage

// ===== csl_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module csl_prog_model (
  input wire logic [2:0] lvl_in, // Level index, 4 = faulty
  output logic [2:0] sec_out // Fuse word
);
  import csl_pkg::*;
  always_comb begin
    case (lvl_in)
      3'h0: sec_out = SEC_NONE;
      3'h1: sec_out = SEC_LVL2;
      3'h2: sec_out = SEC_LVL3;
      3'h3: sec_out = SEC_LVL4;
      3'h5: sec_out = 3'h2; // Commanded fault only
      default: sec_out = 3'h4; // Commanded fault only
    endcase
  end
endmodule
`default_nettype wire

// ===== csl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module csl_sync (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Async reset, active high
  input wire logic d_in, // Asynchronous level
  output logic q_out // Filtered level
);
  import csl_pkg::*;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  // Change accepted only once stages two and three agree
  assign q_nxt = (s2_r == s3_r) ? s3_r : q_r;
  assign q_out = q_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= SYNC_RESET[0];
      s2_r <= SYNC_RESET[0];
      s3_r <= SYNC_RESET[0];
      q_r <= SYNC_RESET[0];
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== csl_top.sv
`timescale 1ns/1ps
`default_nettype none
module csl_top (
  input wire logic REF_CLK_IN, // 20 MHz core clock
  input wire logic RST_IN, // Async reset, active high
  input wire logic [2:0] SEC_BITS_IN, // Fuse states, 1 = programmed, static
  input wire logic EXTERNAL_ACCESS_PIN_IN, // External-access pin level
  input wire csl_pkg::csl_fetch_t FETCH_IN, // Current fetch description
  input wire logic PROG_REQ_IN, // Programming request strobe
  input wire logic VERIFY_REQ_IN, // Verify request strobe
  input wire logic EXT_EXEC_REQ_IN, // Instruction fetch from external memory
  output logic [3:0] LEVEL_OUT, // One-hot protection level
  output logic EXTERNAL_ACCESS_OUT, // Effective external-access level
  output logic CODE_READ_ALLOW_OUT, // Code-table read may return internal byte
  output logic PROG_ALLOW_OUT, // Programming operation accepted
  output logic VERIFY_ALLOW_OUT, // Verify operation accepted
  output logic EXT_EXEC_ALLOW_OUT, // External execution permitted
  output logic PROG_REJECT_OUT, // Pulse: programming request refused
  output logic VERIFY_REJECT_OUT // Pulse: verify request refused
);
  import csl_pkg::*;

  csl_level_t level_r;
  csl_level_t level_nxt;
  csl_prot_t prot;
  logic ea_sync;
  logic ea_latch_r;
  logic ea_latch_nxt;
  logic ea_frozen;
  logic [2:0] age_r;
  logic lvl_is1;
  logic lvl_is2;
  logic lvl_is3;
  logic lvl_is4;
  logic ext_code_read;
  logic prog_rej_r;
  logic verify_rej_r;
  logic bit1;
  logic bit2;
  logic bit3;

  // Three-stage pin filter; a change counts once two stages agree
  csl_sync u_ea_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .d_in(EXTERNAL_ACCESS_PIN_IN),
    .q_out(ea_sync)
  );

  assign bit1 = SEC_BITS_IN[SEC_BIT1];
  assign bit2 = SEC_BITS_IN[SEC_BIT2];
  assign bit3 = SEC_BITS_IN[SEC_BIT3];

  // Fuse word to one-hot level
  always_comb begin
    case (SEC_BITS_IN)
      SEC_NONE: level_nxt = CSL_LVL1;
      SEC_LVL2: level_nxt = CSL_LVL2;
      SEC_LVL3: level_nxt = CSL_LVL3;
      SEC_LVL4: level_nxt = CSL_LVL4;
      default: level_nxt = CSL_LVL4;
    endcase
  end

  assign lvl_is1 = (level_r == CSL_LVL1);
  assign lvl_is2 = (level_r == CSL_LVL2);
  assign lvl_is3 = (level_r == CSL_LVL3);
  assign lvl_is4 = (level_r == CSL_LVL4);

  // Restrictions are cumulative with level
  assign prot.code_read_block = !lvl_is1;
  assign prot.ea_latched_mode = !lvl_is1;
  assign prot.prog_block = !lvl_is1;
  assign prot.verify_block = lvl_is3 || lvl_is4;
  assign prot.ext_exec_block = lvl_is4;

  // Pin follows the filter until it has settled after release, then freezes
  assign ea_frozen = (age_r == EA_SETTLE);
  assign ea_latch_nxt = ea_frozen ? ea_latch_r : ea_sync;

  assign ext_code_read = FETCH_IN.code_table_read && FETCH_IN.from_external &&
                         FETCH_IN.target_internal;

  assign LEVEL_OUT = level_r;
  assign EXTERNAL_ACCESS_OUT = prot.ea_latched_mode ? ea_latch_r : ea_sync;
  assign CODE_READ_ALLOW_OUT = !(ext_code_read && prot.code_read_block);
  assign PROG_ALLOW_OUT = PROG_REQ_IN && !prot.prog_block;
  assign VERIFY_ALLOW_OUT = VERIFY_REQ_IN && !prot.verify_block;
  assign EXT_EXEC_ALLOW_OUT = EXT_EXEC_REQ_IN && !prot.ext_exec_block;
  assign PROG_REJECT_OUT = prog_rej_r;
  assign VERIFY_REJECT_OUT = verify_rej_r;

  // Reset to most restrictive until fuses are sampled
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      level_r <= CSL_LVL4;
      ea_latch_r <= 1'b0;
      prog_rej_r <= 1'b0;
      verify_rej_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      ea_latch_r <= ea_latch_nxt;
      prog_rej_r <= PROG_REQ_IN && prot.prog_block;
      verify_rej_r <= VERIFY_REQ_IN && prot.verify_block;
    end
  end

  // Edge count since release, stops once the pin filter has settled
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      age_r <= 3'h0;
    end else if (!ea_frozen) begin
      age_r <= age_r + 3'h1;
    end
  end

  // Level 1 freedom
  a_lvl1_free: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL1) |-> (PROG_ALLOW_OUT == PROG_REQ_IN) && CODE_READ_ALLOW_OUT)
    else $error("level 1 restricted access");
  a_lvl1_other: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    lvl_is1 |-> (VERIFY_ALLOW_OUT == VERIFY_REQ_IN) && (EXT_EXEC_ALLOW_OUT == EXT_EXEC_REQ_IN))
    else $error("level 1 restricted verify or execution");
  a_reject_lvl1: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    lvl_is1 |=> !PROG_REJECT_OUT && !VERIFY_REJECT_OUT)
    else $error("request rejected at level 1");
  a_ea_live: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    lvl_is1 |-> (EXTERNAL_ACCESS_OUT == ea_sync))
    else $error("access level not live at level 1");

  // Code-table read gating
  a_code_read_block: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r != CSL_LVL1) && ext_code_read |-> !CODE_READ_ALLOW_OUT)
    else $error("external code read leaked internal byte");
  a_code_read_free: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !ext_code_read |-> CODE_READ_ALLOW_OUT)
    else $error("harmless code read refused");

  // Access pin latch
  a_ea_frozen: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ea_frozen && !lvl_is1 |=> $stable(EXTERNAL_ACCESS_OUT))
    else $error("latched access level changed");
  a_ea_window: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !ea_frozen |=> (ea_latch_r == $past(ea_sync)))
    else $error("access level not tracked while settling");

  // Programming
  a_prog_reject: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    PROG_REQ_IN && (level_r != CSL_LVL1) |-> !PROG_ALLOW_OUT ##1 PROG_REJECT_OUT)
    else $error("programming not rejected");
  a_prog_idle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !PROG_REQ_IN |-> !PROG_ALLOW_OUT)
    else $error("programming allowed without request");
  a_prog_no_pulse: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !PROG_REQ_IN |=> !PROG_REJECT_OUT)
    else $error("programming reject without request");

  // Verify
  a_verify_block: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    VERIFY_REQ_IN && (lvl_is3 || lvl_is4) |-> !VERIFY_ALLOW_OUT ##1 VERIFY_REJECT_OUT)
    else $error("verify allowed at level 3 or 4");
  a_lvl2_verify: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL2) |-> (VERIFY_ALLOW_OUT == VERIFY_REQ_IN))
    else $error("verify blocked at level 2");
  a_verify_no_pulse: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !VERIFY_REQ_IN |=> !VERIFY_REJECT_OUT)
    else $error("verify reject without request");

  // External execution
  a_ext_exec_block: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL4) |-> !EXT_EXEC_ALLOW_OUT)
    else $error("external execution at level 4");
  a_exec_free: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !lvl_is4 |-> (EXT_EXEC_ALLOW_OUT == EXT_EXEC_REQ_IN))
    else $error("external execution gated below level 4");

  // Level decode
  a_level_decode: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (SEC_BITS_IN == SEC_LVL3) |=> (level_r == CSL_LVL3))
    else $error("level 3 decode wrong");
  a_lvl1_decode: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (SEC_BITS_IN == SEC_NONE) |=> lvl_is1)
    else $error("level 1 decode wrong");
  a_lvl2_decode: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (SEC_BITS_IN == SEC_LVL2) |=> lvl_is2)
    else $error("level 2 decode wrong");
  a_lvl4_decode: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (SEC_BITS_IN == SEC_LVL4) |=> lvl_is4)
    else $error("level 4 decode wrong");
  a_level_onehot: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    $onehot(level_r))
    else $error("level not one-hot");

  // Undefined fuse words
  a_undef_max: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    bit3 && !(bit1 && bit2) |=> (level_r == CSL_LVL4) && !VERIFY_ALLOW_OUT)
    else $error("undefined pattern not most restrictive");
  a_undef_low: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    bit2 && !bit1 |=> lvl_is4 && !VERIFY_ALLOW_OUT)
    else $error("undefined low pattern not most restrictive");

  // Reset
  a_reset_strict: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (age_r == 3'h0) |-> (level_r == CSL_LVL4))
    else $error("level not strict at reset release");

  // Main scenarios
  c_lvl1: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL1) && PROG_ALLOW_OUT);
  c_lvl2_read: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL2) && ext_code_read);
  c_lvl3_verify: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL3) && VERIFY_REQ_IN);
  c_lvl4_exec: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (level_r == CSL_LVL4) && EXT_EXEC_REQ_IN);
  c_undef_fuse: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (bit3 || bit2) && !bit1 && lvl_is4);
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csl_pkg::*;
  logic clk, rst, ea, prq, vrq, xrq, ea_o, cr, pa, va, xa, pr, vr;
  logic [2:0] lvl, sec;
  logic [3:0] level;
  csl_fetch_t fetch;
  int error_cnt = 0;
  int n_compared = 0;
  csl_prog_model u_csl_prog_model (.lvl_in(lvl), .sec_out(sec));
  csl_top u_csl_top (
    .REF_CLK_IN(clk), .RST_IN(rst), .SEC_BITS_IN(sec),
    .EXTERNAL_ACCESS_PIN_IN(ea), .FETCH_IN(fetch), .PROG_REQ_IN(prq),
    .VERIFY_REQ_IN(vrq), .EXT_EXEC_REQ_IN(xrq), .LEVEL_OUT(level),
    .EXTERNAL_ACCESS_OUT(ea_o), .CODE_READ_ALLOW_OUT(cr), .PROG_ALLOW_OUT(pa),
    .VERIFY_ALLOW_OUT(va), .EXT_EXEC_ALLOW_OUT(xa), .PROG_REJECT_OUT(pr),
    .VERIFY_REJECT_OUT(vr)
  );
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task do_reset;
    rst = 1;
    repeat (8) @(negedge clk);
    rst = 0;
  endtask
  // Every level plus two undefined fuse words
  task t_levels;
    logic [3:0] e;
    for (int i = 0; i < 6; i++) begin
      lvl = i[2:0];
      repeat (2) @(negedge clk);
      e = (i > 3) ? 4'h8 : 4'h1 << i;
      chk("level", level, e);
      {prq, vrq, xrq} = 3'h7;
      fetch = 3'h7;
      #1;
      chk("allows", {cr, pa, va, xa}, {e[0], e[0], e[0] | e[1], ~e[3]});
      @(negedge clk);
      {prq, vrq, xrq} = 3'h0;
      fetch = 3'h5;
      #1;
      chk("local read", {3'h0, cr}, 4'h1);
      chk("idle allows", {1'b0, pa, va, xa}, 4'h0);
      chk("rejects", {2'h0, pr, vr}, {2'h0, ~e[0], e[2] | e[3]});
      @(negedge clk);
      chk("reject pulse", {2'h0, pr, vr}, 4'h0);
    end
    $display("level test done");
  endtask
  // Pin latched at level 2, live at level 1
  task t_ea;
    lvl = 3'h1;
    ea = 1;
    do_reset;
    repeat (8) @(negedge clk);
    chk("ea latched", {3'h0, ea_o}, 4'h1);
    ea = 0;
    repeat (8) @(negedge clk);
    chk("ea frozen", {3'h0, ea_o}, 4'h1);
    lvl = 3'h0;
    do_reset;
    repeat (8) @(negedge clk);
    chk("ea live low", {3'h0, ea_o}, 4'h0);
    ea = 1;
    repeat (8) @(negedge clk);
    chk("ea live high", {3'h0, ea_o}, 4'h1);
    $display("pin latch test done");
  endtask
  initial begin
    {rst, ea, prq, vrq, xrq} = 5'h10;
    lvl = 3'h0;
    fetch = 3'h0;
    @(negedge clk);
    do_reset;
    t_levels;
    t_ea;
    finish_test;
  end
  initial begin
    #(50 * 1000);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
